// >>> rtl/mct_defs.svh
// register offsets, field positions and the channel count of the match/capture timer
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH
`define MCT_OFF_CTRL      12'h000
`define MCT_OFF_COUNT     12'h004
`define MCT_OFF_PRESCALE  12'h008
`define MCT_OFF_PCOUNT    12'h00c
`define MCT_OFF_MATCHCTL  12'h010
`define MCT_OFF_EMCTL     12'h014
`define MCT_OFF_CAPCTL    12'h018
`define MCT_OFF_FLAGS     12'h01c
`define MCT_OFF_PWMCTL    12'h020
`define MCT_OFF_OUTS      12'h024
`define MCT_OFF_MATCH0    12'h040
`define MCT_OFF_CAP0      12'h060
`define MCT_CTRL_EN       0
`define MCT_CTRL_CRST     1
`define MCT_CTRL_CNTMODE  2
`define MCT_CTRL_CLRCAP   4
`define MCT_CTRL_CLREN    6
`define MCT_CTRL_CLREDGE  7
`define MCT_NCH           4
`define MCT_ZERO32        32'h0000_0000
`endif

// >>> rtl/mct_pkg.sv
// types of the match/capture timer
package mct_pkg;
   typedef enum logic [1:0] {MCT_EM_NONE, MCT_EM_LOW, MCT_EM_HIGH, MCT_EM_TOGGLE} mct_em_t;
   typedef enum logic [1:0] {MCT_CNT_TIMER, MCT_CNT_RISE, MCT_CNT_FALL, MCT_CNT_BOTH} mct_cnt_t;
endpackage : mct_pkg

// >>> rtl/mct_edge.sv
// edge detector for one externally sampled input with selectable edge
`timescale 1ns/100ps
module mct_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sig,
   input wire logic rise_en,
   input wire logic fall_en,
   output logic hit
);
   typedef struct packed {
      logic prev;
   } mct_edge_st_t;
   mct_edge_st_t st_reg;
   mct_edge_st_t st_next;
   always_comb begin
      st_next = st_reg;
      st_next.prev = sig;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   // combinational pulse, one cycle, registered by the caller
   assign hit = (rise_en & sig & ~st_reg.prev) | (fall_en & ~sig & st_reg.prev);
endmodule : mct_edge

// >>> rtl/mct_timer.sv
// general counter timer: prescaler, four match and four capture channels, apb slave
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "mct_defs.svh"
// Overview of operation
// - 32-bit count advanced through a 32-bit programmable prescaler.
// - timer mode counts pclk; counter mode counts edges of an external clock.
// - four 32-bit match registers; on match counting may continue, flag optional.
// - stop-on-match halts counting when count equals the match value.
// - reset-on-match returns count to zero on the match.
// - four match outputs each go low, high, toggle or stay on match.
// - four 32-bit capture channels latch the count on a chosen input edge.
// - a capture may raise an interrupt flag.
// - a selected capture edge can clear both count and prescaler.
// - match 0 and 1 can issue a DMA request on match.
// - pwm mode lets match channels 0 to 2 drive pwm outputs.
module mct_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clk,
   input wire logic [3:0] cap_in,
   output logic [3:0] match_out,
   output logic [1:0] dma_req,
   output logic irq_flag_any
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] ctrl;
      logic [31:0] count;
      logic [31:0] prescale;
      logic [31:0] pcount;
      logic [11:0] matchctl;
      logic [7:0] emctl;
      logic [11:0] capctl;
      logic [7:0] flags;
      logic [2:0] pwmctl;
      logic [3:0] outs;
      logic [1:0] dma;
      logic irq;
      logic [3:0][31:0] match;
      logic [3:0][31:0] cap;
   } mct_st_t;

   mct_st_t st_reg;
   mct_st_t st_next;
   logic [3:0] cap_hit;
   logic ext_hit;
   logic [3:0] cap_rise;
   logic [3:0] cap_fall;
   logic setup;
   logic wr;
   logic [31:0] cnt_plus;
   logic [3:0] mhit;
   logic [1:0] cnt_sel;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & st_reg.pready;
   assign cnt_plus = st_reg.count + 32'h0000_0001;
   assign cnt_sel = st_reg.ctrl[`MCT_CTRL_CNTMODE +: 2];

   genvar gi;
   generate
      for (gi = 0; gi < `MCT_NCH; gi++) begin : g_cap
         assign cap_rise[gi] = st_reg.capctl[3*gi];
         assign cap_fall[gi] = st_reg.capctl[3*gi+1];
         mct_edge u_edge (
            .pclk(pclk),
            .presetn(presetn),
            .sig(cap_in[gi]),
            .rise_en(cap_rise[gi]),
            .fall_en(cap_fall[gi]),
            .hit(cap_hit[gi])
         );
         assign mhit[gi] = (st_reg.count == st_reg.match[gi]);
      end
   endgenerate

   // external count clock is one more sampled input, edge picked by the mode
   mct_edge u_ext (
      .pclk(pclk),
      .presetn(presetn),
      .sig(ext_clk),
      .rise_en(cnt_sel[0]),
      .fall_en(cnt_sel[1]),
      .hit(ext_hit)
   );

   always_comb begin
      logic tick;
      logic pre_wrap;
      logic clr_cap;
      logic [3:0] mfire;
      logic [31:0] rd;
      logic [11:0] a;
      logic [7:0] fset;
      tick = 1'b0;
      pre_wrap = 1'b0;
      clr_cap = 1'b0;
      mfire = 4'h0;
      rd = 32'h0000_0000;
      a = paddr;
      fset = 8'h00;
      st_next = st_reg;
      st_next.dma = 2'h0;
      // bus answers one cycle after setup: pready rises for the access phase only
      st_next.pready = setup;
      st_next.pslverr = 1'b0;

      // prescale and count step; a match is acted on once per count value, at its step
      if (st_reg.ctrl[`MCT_CTRL_EN] && !st_reg.ctrl[`MCT_CTRL_CRST]) begin
         tick = (cnt_sel == mct_pkg::MCT_CNT_TIMER) ? 1'b1 : ext_hit;
         if (tick) begin
            pre_wrap = (st_reg.pcount >= st_reg.prescale);
            st_next.pcount = pre_wrap ? `MCT_ZERO32 : st_reg.pcount + 32'h0000_0001;
            if (pre_wrap) begin
               st_next.count = cnt_plus;
               mfire = mhit;
            end
         end
      end
      for (int i = 0; i < `MCT_NCH; i++) begin
         if (mfire[i]) begin
            if (st_reg.matchctl[3*i]) st_next.flags[i] = 1'b1;
            fset[i] = st_reg.matchctl[3*i];
            if (st_reg.matchctl[3*i+1]) st_next.count = `MCT_ZERO32;
            if (st_reg.matchctl[3*i+2]) begin
               st_next.ctrl[`MCT_CTRL_EN] = 1'b0;
               // halted count keeps the matched value unless a reset already took it to zero
               if (st_next.count == cnt_plus) st_next.count = st_reg.count;
            end
            case (mct_pkg::mct_em_t'(st_reg.emctl[2*i +: 2]))
               mct_pkg::MCT_EM_LOW: st_next.outs[i] = 1'b0;
               mct_pkg::MCT_EM_HIGH: st_next.outs[i] = 1'b1;
               mct_pkg::MCT_EM_TOGGLE: st_next.outs[i] = ~st_reg.outs[i];
               default: st_next.outs[i] = st_reg.outs[i];
            endcase
         end
      end
      // pwm: output low from cycle start, high once count steps past match; match3 sets period
      for (int i = 0; i < 3; i++) begin
         if (st_reg.pwmctl[i]) begin
            if (mfire[3]) begin
               st_next.outs[i] = 1'b0;
            end else if (mfire[i]) begin
               st_next.outs[i] = 1'b1;
            end
         end
      end
      st_next.dma = mfire[1:0];

      for (int i = 0; i < `MCT_NCH; i++) begin
         if (cap_hit[i]) begin
            st_next.cap[i] = st_reg.count;
            if (st_reg.capctl[3*i+2]) st_next.flags[4+i] = 1'b1;
            fset[4+i] = st_reg.capctl[3*i+2];
         end
      end
      clr_cap = st_reg.ctrl[`MCT_CTRL_CLREN] && cap_hit[st_reg.ctrl[`MCT_CTRL_CLRCAP +: 2]];
      if (clr_cap || st_reg.ctrl[`MCT_CTRL_CRST]) begin
         st_next.count = `MCT_ZERO32;
         st_next.pcount = `MCT_ZERO32;
      end

      case (a)
         `MCT_OFF_CTRL: rd = {24'h000000, st_reg.ctrl};
         `MCT_OFF_COUNT: rd = st_reg.count;
         `MCT_OFF_PRESCALE: rd = st_reg.prescale;
         `MCT_OFF_PCOUNT: rd = st_reg.pcount;
         `MCT_OFF_MATCHCTL: rd = {20'h00000, st_reg.matchctl};
         `MCT_OFF_EMCTL: rd = {24'h000000, st_reg.emctl};
         `MCT_OFF_CAPCTL: rd = {20'h00000, st_reg.capctl};
         `MCT_OFF_FLAGS: rd = {24'h000000, st_reg.flags};
         `MCT_OFF_PWMCTL: rd = {29'h00000000, st_reg.pwmctl};
         `MCT_OFF_OUTS: rd = {28'h0000000, st_reg.outs};
         12'h040, 12'h044, 12'h048, 12'h04c: rd = st_reg.match[a[3:2]];
         12'h060, 12'h064, 12'h068, 12'h06c: rd = st_reg.cap[a[3:2]];
         default: rd = 32'h0000_0000;
      endcase
      if (setup) begin
         st_next.prdata = rd;
         st_next.pslverr = (rd == 32'h0000_0000) && (a > `MCT_OFF_CAP0 + 12'h00c ||
            (a > `MCT_OFF_OUTS && a < `MCT_OFF_MATCH0) ||
            (a > `MCT_OFF_MATCH0 + 12'h00c && a < `MCT_OFF_CAP0) || a[1:0] != 2'h0);
      end

      if (wr && !st_reg.pslverr) begin
         case (a)
            `MCT_OFF_CTRL: st_next.ctrl = pwdata[7:0];
            `MCT_OFF_COUNT: st_next.count = pwdata;
            `MCT_OFF_PRESCALE: st_next.prescale = pwdata;
            `MCT_OFF_PCOUNT: st_next.pcount = pwdata;
            `MCT_OFF_MATCHCTL: st_next.matchctl = pwdata[11:0];
            `MCT_OFF_EMCTL: st_next.emctl = pwdata[7:0];
            `MCT_OFF_CAPCTL: st_next.capctl = pwdata[11:0];
            // hardware set in this same cycle wins over the clear
            `MCT_OFF_FLAGS: st_next.flags = st_next.flags & ~(pwdata[7:0] & ~fset);
            `MCT_OFF_PWMCTL: st_next.pwmctl = pwdata[2:0];
            `MCT_OFF_OUTS: st_next.outs = pwdata[3:0];
            12'h040, 12'h044, 12'h048, 12'h04c: st_next.match[a[3:2]] = pwdata;
            default: st_next.match = st_next.match;
         endcase
      end
      st_next.irq = |st_next.flags;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign match_out = st_reg.outs;
   assign dma_req = st_reg.dma;
   assign irq_flag_any = st_reg.irq;

   AST_PRESCALE_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[0] && !st_reg.ctrl[1] && cnt_sel == 2'h0 && st_reg.pcount < st_reg.prescale
      && !(|cap_hit) && !wr |=> st_reg.pcount == $past(st_reg.pcount) + 32'h0000_0001)
      else $error("prescale counter did not advance");
   AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[0] && !st_reg.ctrl[1] && cnt_sel == 2'h0 && st_reg.pcount >= st_reg.prescale
      && st_reg.matchctl == 12'h000 && !(|cap_hit) && !wr |=> st_reg.count == $past(cnt_plus))
      else $error("count did not step on prescale wrap");
   AST_HOLD_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.ctrl[0] && !st_reg.ctrl[1] && !(|cap_hit) && !wr |=> $stable(st_reg.count))
      else $error("count moved while disabled");
   AST_STOP_ON_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
      mfire_chk(3'd2) |=> !st_reg.ctrl[0])
      else $error("stop on match failed");
   AST_RESET_ON_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
      mfire_chk(3'd1) && !wr |=> st_reg.count == 32'h0000_0000)
      else $error("reset on match failed");
   AST_MATCH_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      mfire_chk(3'd0) |=> st_reg.flags[0] ##1 st_reg.flags[0] || $past(wr))
      else $error("match flag not set");
   AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
      cap_hit[1] |=> st_reg.cap[1] == $past(st_reg.count))
      else $error("capture did not latch count");
   AST_CAP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      cap_hit[2] && st_reg.capctl[8] |=> st_reg.flags[6])
      else $error("capture flag not set");
   AST_CAP_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[6] && cap_hit[st_reg.ctrl[5:4]] && !wr |=>
      st_reg.count == 32'h0000_0000 && st_reg.pcount == 32'h0000_0000)
      else $error("capture clear failed");
   AST_DMA: assert property (@(posedge pclk) disable iff (!presetn)
      dma_req[0] |-> $past(st_reg.count) == $past(st_reg.match[0]) ##1 !dma_req[0] ||
      $past(mhit[0]))
      else $error("dma request without match");
   AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.flags[5] && !(wr && paddr == 12'h01c && pwdata[5]) |=> st_reg.flags[5])
      else $error("flag dropped without a write of one");

   // count step as the checks below see it, rebuilt from the registered state
   logic chk_step;
   assign chk_step = st_reg.ctrl[0] && !st_reg.ctrl[1] && st_reg.pcount >= st_reg.prescale
      && (cnt_sel == 2'h0 || ext_hit);

   AST_PWM_SET: assert property (@(posedge pclk) disable iff (!presetn)
      chk_step && st_reg.pwmctl[1] && mhit[1] && !mhit[3] && !wr |=> match_out[1])
      else $error("pwm output not set at its match");
   AST_PWM_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      chk_step && st_reg.pwmctl[1] && mhit[3] && !wr |=> !match_out[1])
      else $error("pwm output not cleared at period end");
   AST_EM_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      chk_step && mhit[0] && st_reg.emctl[1:0] == 2'h2 && !st_reg.pwmctl[0] && !wr
      |=> match_out[0])
      else $error("match output not driven high");
   AST_EM_NONE: assert property (@(posedge pclk) disable iff (!presetn)
      chk_step && mhit[1] && st_reg.emctl[3:2] == 2'h0 && !st_reg.pwmctl[1] && !wr
      |=> $stable(match_out[1]))
      else $error("match output moved with no action set");
   AST_DMA_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      chk_step && mhit[1] |=> dma_req[1])
      else $error("dma request 1 missing on match");
   AST_CAP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.capctl[3] && !st_reg.capctl[4] |-> !cap_hit[1])
      else $error("capture fired with no edge selected");
   AST_PCOUNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.ctrl[0] && !st_reg.ctrl[1] && !(|cap_hit) && !wr |=> $stable(st_reg.pcount))
      else $error("prescale counter moved while disabled");
   AST_EXT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[0] && !st_reg.ctrl[1] && cnt_sel != 2'h0 && !ext_hit && !(|cap_hit) && !wr
      |=> $stable(st_reg.count))
      else $error("count moved without an external edge");

   function automatic logic mfire_chk(input logic [2:0] bitsel);
      mfire_chk = st_reg.ctrl[0] && !st_reg.ctrl[1] && cnt_sel == 2'h0
         && st_reg.pcount >= st_reg.prescale && mhit[0] && st_reg.matchctl[bitsel];
   endfunction : mfire_chk
endmodule : mct_timer

// >>> test/mct_pins.sv
// far-side model: external count clock, capture inputs, watcher of dma lines
`timescale 1ns/100ps
module mct_pins (
   input wire logic pclk,
   output logic ext_clk,
   output logic [3:0] cap_in,
   input wire logic [3:0] match_out,
   input wire logic [1:0] dma_req
);
   logic [1:0] dma_seen;
   initial begin
      ext_clk = 1'b0;
      cap_in = 4'h0;
      dma_seen = 2'h0;
   end
   // a one-cycle pulse is easy to miss from the bench, so latch it here
   always @(posedge pclk) begin
      dma_seen <= dma_seen | dma_req;
   end
   // levels change right after an edge and stay 3 cycles so the edge detector sees them
   task pulse_ext(input int n);
      repeat (n) begin
         @(posedge pclk);
         ext_clk <= 1'b1;
         repeat (3) @(posedge pclk);
         ext_clk <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask : pulse_ext
   task pulse_cap(input int ch);
      @(posedge pclk);
      cap_in[ch] <= 1'b1;
      repeat (3) @(posedge pclk);
      cap_in[ch] <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : pulse_cap
endmodule : mct_pins

// >>> test/match_capture_timer_bench.sv
// self-checking bench of the match/capture timer over apb
`timescale 1ns/100ps
`include "mct_defs.svh"
module match_capture_timer_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_clk, irq_flag_any;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] cap_in, match_out;
   logic [1:0] dma_req;
   int n_errors = 0;
   int comparisons = 0;
   int k;
   int hi;
   mct_timer mct_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clk(ext_clk), .cap_in(cap_in), .match_out(match_out),
      .dma_req(dma_req), .irq_flag_any(irq_flag_any));
   mct_pins mct_pins_inst (.pclk(pclk), .ext_clk(ext_clk), .cap_in(cap_in),
      .match_out(match_out), .dma_req(dma_req));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task complete_run;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk32
   task chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk1
   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      if (n >= 50) n_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk32(rd, exp);
   endtask : rdchk
   initial begin
      #(100 * 20000);
      n_errors++;
      complete_run();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`MCT_OFF_CTRL, 32'h0000_0000);
      rdchk(`MCT_OFF_PRESCALE, 32'h0000_0000);
      apb(1'b0, 12'h0f0, 32'h0000_0000);
      chk1(pslverr, 1'b1);
      chk32(rd, 32'h0000_0000);
      // stop on match 0 with flag, output high, prescale 1
      apb(1'b1, `MCT_OFF_PRESCALE, 32'h0000_0001);
      apb(1'b1, `MCT_OFF_MATCH0, 32'h0000_0004);
      apb(1'b1, `MCT_OFF_MATCHCTL, 32'h0000_0005);
      apb(1'b1, `MCT_OFF_EMCTL, 32'h0000_0002);
      apb(1'b1, `MCT_OFF_CTRL, 32'h0000_0001);
      k = 0;
      while (irq_flag_any !== 1'b1 && k < 200) begin
         k++;
         @(posedge pclk);
      end
      if (k >= 200) n_errors++;
      repeat (10) @(posedge pclk);
      rdchk(`MCT_OFF_COUNT, 32'h0000_0004);
      chk1(match_out[0], 1'b1);
      chk1(mct_pins_inst.dma_seen[0], 1'b1);
      rdchk(`MCT_OFF_FLAGS, 32'h0000_0001);
      // capture on rising edge of input 1 while count is held at 4
      apb(1'b1, `MCT_OFF_CAPCTL, 32'h0000_0028);
      mct_pins_inst.pulse_cap(1);
      rdchk(`MCT_OFF_CAP0 + 12'h004, 32'h0000_0004);
      rdchk(`MCT_OFF_FLAGS, 32'h0000_0021);
      repeat (5) @(posedge pclk);
      rdchk(`MCT_OFF_FLAGS, 32'h0000_0021);
      apb(1'b1, `MCT_OFF_FLAGS, 32'h0000_0021);
      rdchk(`MCT_OFF_FLAGS, 32'h0000_0000);
      chk1(irq_flag_any, 1'b0);
      // counter mode on external rising edges, prescale 0
      apb(1'b1, `MCT_OFF_MATCHCTL, 32'h0000_0000);
      apb(1'b1, `MCT_OFF_PRESCALE, 32'h0000_0000);
      apb(1'b1, `MCT_OFF_CTRL, 32'h0000_0002);
      apb(1'b1, `MCT_OFF_CTRL, 32'h0000_0005);
      mct_pins_inst.pulse_ext(3);
      repeat (4) @(posedge pclk);
      rdchk(`MCT_OFF_COUNT, 32'h0000_0003);
      // pwm on output 1: match 0 resets at 5, match 3 ends the period, match 1 sets at 2
      apb(1'b1, `MCT_OFF_MATCH0, 32'h0000_0005);
      apb(1'b1, `MCT_OFF_MATCH0 + 12'h004, 32'h0000_0002);
      apb(1'b1, `MCT_OFF_MATCH0 + 12'h00c, 32'h0000_0005);
      apb(1'b1, `MCT_OFF_MATCHCTL, 32'h0000_0002);
      apb(1'b1, `MCT_OFF_PWMCTL, 32'h0000_0002);
      apb(1'b1, `MCT_OFF_CTRL, 32'h0000_0002);
      apb(1'b1, `MCT_OFF_CTRL, 32'h0000_0001);
      repeat (12) @(posedge pclk);
      hi = 0;
      repeat (12) begin
         @(posedge pclk);
         if (match_out[1] === 1'b1) hi++;
      end
      chk32(hi, 32'h0000_0006);
      apb(1'b0, `MCT_OFF_COUNT, 32'h0000_0000);
      chk1(rd < 32'h0000_0006, 1'b1);
      // pulse width on capture 2: both edges latch the count and clear count and prescaler; the falling edge latches the width
      apb(1'b1, `MCT_OFF_CAPCTL, 32'h0000_01c0);
      apb(1'b1, `MCT_OFF_CTRL, 32'h0000_0061);
      mct_pins_inst.pulse_cap(2);
      rdchk(`MCT_OFF_CAP0 + 12'h008, 32'h0000_0002);
      rdchk(`MCT_OFF_FLAGS, 32'h0000_0040);
      complete_run();
   end
endmodule : match_capture_timer_bench
